/* core/tpg_gpio_bank.sv */
/*
  Three 8-bit GPIO ports with output data, pin state, drive enable and
  alternate-function select registers, reached as an APB slave.
  Assumes alternate-function signals are synchronous inputs, pins pass a two-stage synchroniser, and
  that the pad ring resolves each pin from pin_out and pin_oe.
*/
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - A pin is driven from its output data bit only while its drive enable is 1 and alternate select is 0.
// - With drive enable 0, writes to the output data bit are still stored but not driven onto the pin.
// - Reading a pin-state register returns every pin level of the port, plain IO or alternate function.
// - Each drive-enable bit controls the tri-state driver; 1 makes an output unless alternate select is 1.
// - One read/write output data register per port at consecutive addresses, each bit resetting to 0.
// - Pin-state registers are read-only, one bit per pin, following the external pin levels.
// - Drive-enable registers are read/write, one bit per pin.
// - An alternate select bit of 1 hands the pin to its alternate peripheral function.
module tpg_gpio_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tpg_pkg::ADDR_W-1:0] paddr,
  input wire logic [tpg_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [tpg_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [tpg_pkg::PORT_W-1:0] pin_in_a,
  input wire logic [tpg_pkg::PORT_W-1:0] pin_in_b,
  input wire logic [tpg_pkg::PORT_W-1:0] pin_in_c,
  output logic [tpg_pkg::PORT_W-1:0] pin_out_a,
  output logic [tpg_pkg::PORT_W-1:0] pin_out_b,
  output logic [tpg_pkg::PORT_W-1:0] pin_out_c,
  output logic [tpg_pkg::PORT_W-1:0] pin_oe_a,
  output logic [tpg_pkg::PORT_W-1:0] pin_oe_b,
  output logic [tpg_pkg::PORT_W-1:0] pin_oe_c,
  input wire logic [tpg_pkg::PORT_W-1:0] alt_out_a,
  input wire logic [tpg_pkg::PORT_W-1:0] alt_out_b,
  input wire logic [tpg_pkg::PORT_W-1:0] alt_out_c,
  input wire logic [tpg_pkg::PORT_W-1:0] alt_oe_a,
  input wire logic [tpg_pkg::PORT_W-1:0] alt_oe_b,
  input wire logic [tpg_pkg::PORT_W-1:0] alt_oe_c
);
  import tpg_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [NUM_PORTS-1:0][PORT_W-1:0] out_data;
    logic [NUM_PORTS-1:0][PORT_W-1:0] drive_en;
    logic [NUM_PORTS-1:0][PORT_W-1:0] alt_sel;
    logic [NUM_PORTS-1:0][PORT_W-1:0] pin_out;
    logic [NUM_PORTS-1:0][PORT_W-1:0] pin_oe;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } tpg_state_s;

  // Drive enables come up low so no pin fights the board after reset
  localparam tpg_state_s RESET_STATE = '{
    out_data: {NUM_PORTS{RST_OUTPUT_DATA}},
    drive_en: {NUM_PORTS{RST_DRIVE_ENABLE}},
    alt_sel: {NUM_PORTS{RST_ALT_SELECT}},
    pin_out: {NUM_PORTS{RST_OUTPUT_DATA}},
    pin_oe: {NUM_PORTS{RST_DRIVE_ENABLE}},
    prdata: '0,
    pready: 1'b0,
    pslverr: 1'b0
  };

  tpg_state_s state_reg;
  tpg_state_s state_next;

  logic [NUM_PORTS-1:0][PORT_W-1:0] pin_in_all;
  logic [NUM_PORTS-1:0][PORT_W-1:0] alt_out_all;
  logic [NUM_PORTS-1:0][PORT_W-1:0] alt_oe_all;
  logic [NUM_PORTS-1:0][PORT_W-1:0] pin_sync;
  tpg_dec_s dec;
  logic setup;
  logic wr_fire;
  logic bad_access;
  logic [PORT_W-1:0] rd_byte;

  assign pin_in_all = {pin_in_c, pin_in_b, pin_in_a};
  assign alt_out_all = {alt_out_c, alt_out_b, alt_out_a};
  assign alt_oe_all = {alt_oe_c, alt_oe_b, alt_oe_a};

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  tpg_sync #(
    .W(NUM_PORTS * PORT_W)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .d(pin_in_all),
    .q(pin_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // APB decode

  // Misaligned byte addresses are treated as unmapped
  assign dec = (paddr[1:0] == 2'h0) ? tpg_decode(paddr[FIELD_LSB+17:FIELD_LSB+2])
                                    : tpg_dec_s'{kind: KIND_NONE, port: 2'h0};
  assign setup = psel && !penable;
  assign bad_access = (dec.kind == KIND_NONE) || (pwrite && dec.kind == KIND_PIN);
  assign wr_fire = psel && penable && state_reg.pready && pwrite && !state_reg.pslverr;

  always_comb begin
    case (dec.kind)
      KIND_ALT: rd_byte = state_reg.alt_sel[dec.port];
      KIND_OUT: rd_byte = state_reg.out_data[dec.port];
      KIND_PIN: rd_byte = pin_sync[dec.port];
      KIND_OE: rd_byte = state_reg.drive_en[dec.port];
      default: rd_byte = '0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_next = state_reg;
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    state_next.prdata = '0;
    // Answer is prepared in the setup cycle so the access phase has no wait
    if (setup) begin
      state_next.pready = 1'b1;
      state_next.pslverr = bad_access;
      if (!pwrite && !bad_access) begin
        state_next.prdata = {{(DATA_W - PORT_W){1'b0}}, rd_byte};
      end
    end
    // Only byte lane 0 carries register data
    if (wr_fire && pstrb[0]) begin
      case (dec.kind)
        KIND_ALT: state_next.alt_sel[dec.port] = pwdata[PORT_W-1:0];
        KIND_OUT: state_next.out_data[dec.port] = pwdata[PORT_W-1:0];
        KIND_OE: state_next.drive_en[dec.port] = pwdata[PORT_W-1:0];
        default: state_next.out_data = state_reg.out_data;
      endcase
    end
    // Output data is latched regardless of the enable; only the pad path is gated
    state_next.pin_out = (state_reg.alt_sel & alt_out_all)
                       | (~state_reg.alt_sel & state_reg.out_data);
    state_next.pin_oe = (state_reg.alt_sel & alt_oe_all)
                      | (~state_reg.alt_sel & state_reg.drive_en);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign pin_out_a = state_reg.pin_out[0];
  assign pin_out_b = state_reg.pin_out[1];
  assign pin_out_c = state_reg.pin_out[2];
  assign pin_oe_a = state_reg.pin_oe[0];
  assign pin_oe_b = state_reg.pin_oe[1];
  assign pin_oe_c = state_reg.pin_oe[2];

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [PORT_W-1:0] wr_byte_q;
  logic [1:0] wr_port_q;
  tpg_kind_e wr_kind_q;
  logic wr_fire_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_byte_q <= 8'h00;
      wr_port_q <= 2'h0;
      wr_kind_q <= KIND_NONE;
      wr_fire_q <= 1'b0;
    end else begin
      wr_byte_q <= pwdata[PORT_W-1:0];
      wr_port_q <= dec.port;
      wr_kind_q <= dec.kind;
      wr_fire_q <= wr_fire && pstrb[0];
    end
  end

  gpio_drive_a: assert property (
    @(posedge clk) disable iff (rst)
    1'b1 |=> ((~$past(state_reg.alt_sel) & $past(state_reg.drive_en)
              & ($past(state_reg.out_data) ^ state_reg.pin_out)) == '0))
    else $error("pin does not follow output data while enabled");

  latch_store_a: assert property (
    @(posedge clk) disable iff (rst)
    wr_fire_q && wr_kind_q == KIND_OUT
    |-> state_reg.out_data[wr_port_q] == wr_byte_q
        ##1 ((state_reg.pin_oe & ~state_reg.alt_sel & ~state_reg.drive_en) == '0))
    else $error("output data write lost or undriven bit enabled");

  tristate_ctrl_a: assert property (
    @(posedge clk) disable iff (rst)
    1'b1 |=> (state_reg.pin_oe == (($past(state_reg.alt_sel) & $past(alt_oe_all))
                                | (~$past(state_reg.alt_sel) & $past(state_reg.drive_en)))))
    else $error("driver enable does not match drive enable and select");

  alt_hand_a: assert property (
    @(posedge clk) disable iff (rst)
    1'b1 |=> (($past(state_reg.alt_sel) & ($past(alt_out_all) ^ state_reg.pin_out)) == '0))
    else $error("alternate function not routed to pin");

  pin_read_a: assert property (
    @(posedge clk) disable iff (rst)
    setup && !pwrite && dec.kind == KIND_PIN
    |=> pready && !pslverr && prdata[PORT_W-1:0] == $past(pin_sync[dec.port]))
    else $error("pin state read returns wrong level");

  pin_ro_a: assert property (
    @(posedge clk) disable iff (rst)
    setup && pwrite && dec.kind == KIND_PIN |=> pready && pslverr ##1 !pready)
    else $error("write to pin state not refused");

  out_reset_a: assert property (
    @(posedge clk)
    rst |-> state_reg.out_data == '0 && state_reg.pin_oe == '0 && !pready)
    else $error("output data not cleared by reset");

  enable_rw_a: assert property (
    @(posedge clk) disable iff (rst)
    wr_fire_q && wr_kind_q == KIND_OE |-> state_reg.drive_en[wr_port_q] == wr_byte_q)
    else $error("drive enable write not stored");

  sync_delay_a: assert property (
    @(posedge clk) disable iff (rst)
    1'b1 |-> ##2 pin_sync == $past(pin_in_all, 2))
    else $error("pin level not delayed by two stages");

  apb_ready_a: assert property (
    @(posedge clk) disable iff (rst)
    setup |=> pready ##1 !pready)
    else $error("access phase not answered in one cycle");

  //////////////////////////////////////////////////////////////////////////////
  // Bus refusals, handshake, register read-back and storage, alternate enable routing

  misalign_err_a: assert property (
    @(posedge clk) disable iff (rst)
    setup && paddr[1:0] != 2'h0
    |=> pready && pslverr && prdata == '0)
    else $error("misaligned access not refused");

  unmapped_err_a: assert property (
    @(posedge clk) disable iff (rst)
    setup && dec.kind == KIND_NONE
    |=> pready && pslverr && prdata == '0)
    else $error("unmapped access not refused");

  strobe_gate_a: assert property (
    @(posedge clk) disable iff (rst)
    psel && penable && pwrite && !pstrb[0]
    |=> $stable(state_reg.out_data) && $stable(state_reg.drive_en) && $stable(state_reg.alt_sel))
    else $error("write without lane zero strobe changed a register");

  answer_idle_a: assert property (
    @(posedge clk) disable iff (rst)
    !pready
    |-> prdata == '0 && !pslverr)
    else $error("read data or error shown outside the answer cycle");

  ready_pulse_a: assert property (
    @(posedge clk) disable iff (rst)
    pready
    |=> !pready)
    else $error("ready held past one cycle");

  ready_cause_a: assert property (
    @(posedge clk) disable iff (rst)
    pready
    |-> $past(setup))
    else $error("ready raised without a setup cycle");

  out_read_a: assert property (
    @(posedge clk) disable iff (rst)
    setup && !pwrite && dec.kind == KIND_OUT
    |=> prdata[PORT_W-1:0] == $past(state_reg.out_data[dec.port]))
    else $error("output data read back wrong");

  oe_read_a: assert property (
    @(posedge clk) disable iff (rst)
    setup && !pwrite && dec.kind == KIND_OE
    |=> prdata[PORT_W-1:0] == $past(state_reg.drive_en[dec.port]))
    else $error("drive enable read back wrong");

  alt_read_a: assert property (
    @(posedge clk) disable iff (rst)
    setup && !pwrite && dec.kind == KIND_ALT
    |=> prdata[PORT_W-1:0] == $past(state_reg.alt_sel[dec.port]))
    else $error("alternate select read back wrong");

  alt_store_a: assert property (
    @(posedge clk) disable iff (rst)
    wr_fire_q && wr_kind_q == KIND_ALT
    |-> state_reg.alt_sel[wr_port_q] == wr_byte_q)
    else $error("alternate select write not stored");

  out_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    !(wr_fire && pstrb[0] && dec.kind == KIND_OUT)
    |=> $stable(state_reg.out_data))
    else $error("output data changed without a write");

  pin_wr_keep_a: assert property (
    @(posedge clk) disable iff (rst)
    setup && pwrite && dec.kind == KIND_PIN
    |=> ##1 ($stable(state_reg.out_data) && $stable(state_reg.drive_en) && $stable(state_reg.alt_sel)))
    else $error("refused pin state write changed a register");

  upper_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    pready
    |-> prdata[DATA_W-1:PORT_W] == '0)
    else $error("upper read data bits not zero");

  alt_oe_route_a: assert property (
    @(posedge clk) disable iff (rst)
    1'b1
    |=> (($past(state_reg.alt_sel) & ($past(alt_oe_all) ^ state_reg.pin_oe)) == '0))
    else $error("alternate enable not routed to driver");

endmodule // tpg_gpio_bank

`default_nettype wire

/* core/tpg_pkg.sv */
/*
  Constants, types and the address decoder of the three-port GPIO bank.
  Assumes APB with 32-bit data; each register sits in one aligned word
  whose byte address is four times its register index.
*/
`default_nettype none

package tpg_pkg;

  localparam int PORT_W = 8;
  localparam int NUM_PORTS = 3;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int FIELD_LSB = 0;

  typedef logic [15:0] tpg_idx_t;

  //////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is index times four
  localparam tpg_idx_t IDX_PIN_ALT_SELECT_A = 16'h7F93;
  localparam tpg_idx_t IDX_PIN_ALT_SELECT_B = 16'h7F94;
  localparam tpg_idx_t IDX_PIN_ALT_SELECT_C = 16'h7F95;
  localparam tpg_idx_t IDX_PORT_A_OUTPUT_DATA = 16'h7F96;
  localparam tpg_idx_t IDX_PORT_B_OUTPUT_DATA = 16'h7F97;
  localparam tpg_idx_t IDX_PORT_C_OUTPUT_DATA = 16'h7F98;
  localparam tpg_idx_t IDX_PORT_A_PIN_STATE = 16'h7F99;
  localparam tpg_idx_t IDX_PORT_B_PIN_STATE = 16'h7F9A;
  localparam tpg_idx_t IDX_PORT_C_PIN_STATE = 16'h7F9B;
  localparam tpg_idx_t IDX_PORT_A_DRIVE_ENABLE = 16'h7F9C;
  localparam tpg_idx_t IDX_PORT_B_DRIVE_ENABLE = 16'h7F9D;
  localparam tpg_idx_t IDX_PORT_C_DRIVE_ENABLE = 16'h7F9E;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [PORT_W-1:0] RST_OUTPUT_DATA = 8'h00;
  localparam logic [PORT_W-1:0] RST_DRIVE_ENABLE = 8'h00;
  localparam logic [PORT_W-1:0] RST_ALT_SELECT = 8'h00;
  localparam logic [PORT_W-1:0] RST_PIN_SYNC = 8'h00;

  typedef enum logic [4:0] {
    KIND_NONE = 5'h01,
    KIND_ALT = 5'h02,
    KIND_OUT = 5'h04,
    KIND_PIN = 5'h08,
    KIND_OE = 5'h10
  } tpg_kind_e;

  typedef struct packed {
    tpg_kind_e kind;
    logic [1:0] port;
  } tpg_dec_s;

  // Maps a word index onto register kind and port
  function automatic tpg_dec_s tpg_decode(input tpg_idx_t w);
    tpg_dec_s d;
    d.kind = KIND_NONE;
    d.port = 2'h0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (w == IDX_PIN_ALT_SELECT_A + tpg_idx_t'(p)) begin
        d.kind = KIND_ALT;
        d.port = 2'(p);
      end
      if (w == IDX_PORT_A_OUTPUT_DATA + tpg_idx_t'(p)) begin
        d.kind = KIND_OUT;
        d.port = 2'(p);
      end
      if (w == IDX_PORT_A_PIN_STATE + tpg_idx_t'(p)) begin
        d.kind = KIND_PIN;
        d.port = 2'(p);
      end
      if (w == IDX_PORT_A_DRIVE_ENABLE + tpg_idx_t'(p)) begin
        d.kind = KIND_OE;
        d.port = 2'(p);
      end
    end
    return d;
  endfunction

endpackage

`default_nettype wire

/* core/tpg_sync.sv */
/*
  Two-stage synchroniser for a vector of pin levels.
  Assumes each bit is an independent level; no bit-to-bit coherence.
*/
`timescale 1ns/1ps
`default_nettype none

module tpg_sync #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import tpg_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } tpg_sync_s;

  tpg_sync_s sync_reg;
  tpg_sync_s sync_next;

  // First stage feeds only the second stage
  always_comb begin
    sync_next = sync_reg;
    sync_next.meta = d;
    sync_next.q = sync_reg.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.q;

endmodule // tpg_sync

`default_nettype wire

/* sim/tb.sv */
/*
  Self-checking bench for the three-port GPIO bank.
  Assumes an APB answer in the first access cycle and pads modelled per port.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import tpg_pkg::*;
  logic clk = 0, rst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [1:0] addr_lo = 2'h0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'hF;
  wire logic [DATA_W-1:0] prdata;
  wire logic pready, pslverr;
  wire logic [PORT_W-1:0] pin_lvl [3], pin_out [3], pin_oe [3];
  logic [PORT_W-1:0] alt_out [3] = '{default: 8'h00}, alt_oe [3] = '{default: 8'h00};
  logic [PORT_W-1:0] ext_val [3] = '{default: 8'h00}, ext_en [3] = '{default: 8'h00};
  logic [PORT_W-1:0] od [3], de [3], al [3];
  logic [DATA_W:0] exp_q [$];
  int mismatches = 0, total_checks = 0;

  initial forever #4 clk = ~clk;

  tpg_gpio_bank dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in_a(pin_lvl[0]), .pin_in_b(pin_lvl[1]), .pin_in_c(pin_lvl[2]),
    .pin_out_a(pin_out[0]), .pin_out_b(pin_out[1]), .pin_out_c(pin_out[2]),
    .pin_oe_a(pin_oe[0]), .pin_oe_b(pin_oe[1]), .pin_oe_c(pin_oe[2]),
    .alt_out_a(alt_out[0]), .alt_out_b(alt_out[1]), .alt_out_c(alt_out[2]),
    .alt_oe_a(alt_oe[0]), .alt_oe_b(alt_oe[1]), .alt_oe_c(alt_oe[2]));

  for (genvar g = 0; g < 3; g++) begin : g_pad
    tpg_pad_model pad (.drv_val(pin_out[g]), .drv_en(pin_oe[g]), .ext_val(ext_val[g]),
      .ext_en(ext_en[g]), .level(pin_lvl[g]));
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [DATA_W:0] seen, input logic [DATA_W:0] expd);
    total_checks++;
    if (seen !== expd) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Setup edge first so psel never gets two assignments in one time step
  task automatic apb(input logic wr, input tpg_idx_t i, input logic [7:0] d, input logic [3:0] st,
                     input logic [DATA_W:0] expd);
    int n;
    @(posedge clk);
    exp_q.push_back(expd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {i, addr_lo};
    pwdata <= {24'h0, d};
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input tpg_idx_t i, input logic [7:0] v);
    apb(1'b0, i, 8'h00, 4'hF, {25'h0, v});
  endtask

  task automatic wr(input tpg_idx_t i, input logic [7:0] v);
    apb(1'b1, i, v, 4'hF, 33'h0);
  endtask

  function automatic tpg_idx_t ix(input tpg_idx_t base, input int p);
    return tpg_idx_t'(base + tpg_idx_t'(p));
  endfunction

  function automatic logic [7:0] drv_oe(input int p);
    return (al[p] & alt_oe[p]) | (~al[p] & de[p]);
  endfunction

  function automatic logic [7:0] drv_val(input int p);
    return (al[p] & alt_out[p]) | (~al[p] & od[p]);
  endfunction

  // Board level: device drive, else external drive, else pull-up
  function automatic logic [7:0] lvl(input int p);
    return (drv_oe(p) & drv_val(p)) | (~drv_oe(p) & ~(ext_en[p] & ~ext_val[p]));
  endfunction

  // Pads were updated one edge ago; read before this edge's update
  task automatic pin_check();
    repeat (2) @(posedge clk);
    for (int p = 0; p < 3; p++) begin
      check({25'h0, pin_oe[p]}, {25'h0, drv_oe(p)});
      check({25'h0, pin_out[p] & drv_oe(p)}, {25'h0, drv_val(p) & drv_oe(p)});
    end
  endtask

  task automatic reset_check();
    for (int p = 0; p < 3; p++) begin
      od[p] = RST_OUTPUT_DATA;
      de[p] = RST_DRIVE_ENABLE;
      al[p] = RST_ALT_SELECT;
      rd(ix(IDX_PORT_A_OUTPUT_DATA, p), RST_OUTPUT_DATA);
      rd(ix(IDX_PORT_A_DRIVE_ENABLE, p), RST_DRIVE_ENABLE);
      rd(ix(IDX_PIN_ALT_SELECT_A, p), RST_ALT_SELECT);
    end
    pin_check();
  endtask

  // Answers are compared in the access cycle where pready is sampled
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      check({pslverr, prdata}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h1DF0));
    // Raised at time zero by a nonblocking assignment so the asynchronous reset sees a real edge
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    reset_check();
    $display("reset values done");
    for (int p = 0; p < 3; p++) begin
      od[p] = 8'($urandom);
      wr(ix(IDX_PORT_A_OUTPUT_DATA, p), od[p]);
      rd(ix(IDX_PORT_A_OUTPUT_DATA, p), od[p]);
    end
    pin_check();
    for (int p = 0; p < 3; p++) begin
      de[p] = 8'($urandom);
      wr(ix(IDX_PORT_A_DRIVE_ENABLE, p), de[p]);
      rd(ix(IDX_PORT_A_DRIVE_ENABLE, p), de[p]);
    end
    pin_check();
    apb(1'b1, IDX_PORT_A_OUTPUT_DATA, ~od[0], 4'h0, 33'h0);
    addr_lo = 2'h2;
    apb(1'b1, IDX_PORT_A_OUTPUT_DATA, ~od[0], 4'hF, {1'b1, 32'h0});
    apb(1'b0, IDX_PORT_A_OUTPUT_DATA, 8'h00, 4'hF, {1'b1, 32'h0});
    addr_lo = 2'h0;
    rd(IDX_PORT_A_OUTPUT_DATA, od[0]);
    $display("output and drive enable done");
    for (int p = 0; p < 3; p++) begin
      al[p] = 8'($urandom);
      alt_out[p] <= 8'($urandom);
      alt_oe[p] <= 8'($urandom);
      wr(ix(IDX_PIN_ALT_SELECT_A, p), al[p]);
    end
    pin_check();
    $display("alternate select done");
    for (int p = 0; p < 3; p++) begin
      ext_val[p] <= 8'($urandom);
      ext_en[p] <= 8'($urandom);
    end
    repeat (4) @(posedge clk);
    for (int p = 0; p < 3; p++) begin
      rd(ix(IDX_PORT_A_PIN_STATE, p), lvl(p));
      apb(1'b1, ix(IDX_PORT_A_PIN_STATE, p), 8'hA5, 4'hF, {1'b1, 32'h0});
      rd(ix(IDX_PORT_A_PIN_STATE, p), lvl(p));
    end
    apb(1'b0, ix(IDX_PORT_C_DRIVE_ENABLE, 1), 8'h00, 4'hF, {1'b1, 32'h0});
    $display("pin state and refusals done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    reset_check();
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule // tb

`default_nettype wire

/* sim/tpg_pad_model.sv */
/*
  Board-side model of one 8-pin port: resolves each pin level.
  Assumes the device drive wins over the external driver; pins that nobody
  drives are pulled up on the board.
*/
`timescale 1ns/1ps
`default_nettype none

module tpg_pad_model (
  input wire logic [tpg_pkg::PORT_W-1:0] drv_val,
  input wire logic [tpg_pkg::PORT_W-1:0] drv_en,
  input wire logic [tpg_pkg::PORT_W-1:0] ext_val,
  input wire logic [tpg_pkg::PORT_W-1:0] ext_en,
  output logic [tpg_pkg::PORT_W-1:0] level
);
  import tpg_pkg::*;
  // Contention is not modelled: a driving device simply masks the board
  assign level = (drv_en & drv_val) | (~drv_en & ext_en & ext_val) | (~drv_en & ~ext_en);
endmodule // tpg_pad_model

`default_nettype wire
